// >>> core/ebcod_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "ebcod_consts.vh"

// What this block does
// - Decode add forms, bank/direct/immediate/indirect, one cycle
// - Decode add with carry forms, one cycle
// - Decode subtract with borrow forms, one cycle
// - Decode increment forms, one cycle
// - Decode decrement forms, one cycle
// - Code A3 increments data pointer, two cycles
// - Multiply A4 and divide 84, four cycles
// - Code D4 decimal adjusts accumulator, one cycle
// - Decode AND into accumulator, one cycle
// - AND into direct byte, 52 and 53
// - Decode OR into accumulator, one cycle
// - OR into direct byte, 42 and 43
// - Decode XOR into accumulator, direct/immediate/indirect, no bank form, one cycle
// - XOR into direct byte, 62 and 63
// - Clear, complement, nibble swap of accumulator
// - Four accumulator rotations, one cycle each
// - Load accumulator from direct or immediate
// - Bank load: direct two cycles, immediate one
// - Direct destination moves 85, 75, F5
// - Indirect to direct; immediate to indirect
// - Code 90 loads data pointer, three bytes
// - Code 93 reads code byte, two cycles
module ebcod_decoder #(
    parameter [15:0] RESET_PC = `EBCOD_RESET_PC
) (
    // Clock and reset
    input  wire        sys_clk_in,
    input  wire        resetn_in,
    // Program memory fetch
    output wire        code_rd_out,
    output wire [15:0] code_addr_out,
    input  wire        code_ack_in,
    input  wire [7:0]  code_data_in,
    // Decoded instruction
    output wire        instr_start_out,
    output wire        exec_active_out,
    output wire [7:0]  opcode_out,
    output wire [4:0]  op_class_out,
    output wire [2:0]  src_sel_out,
    output wire [2:0]  dst_sel_out,
    output wire [2:0]  bank_idx_out,
    output wire        ptr_idx_out,
    output wire [1:0]  instr_len_out,
    output wire [2:0]  exec_cycles_out,
    output wire [7:0]  operand1_out,
    output wire [7:0]  operand2_out,
    output wire        unknown_op_out
);

    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg [15:0] pc_reg;
    reg [7:0]  opc_reg;
    reg [4:0]  cls_reg;
    reg [2:0]  src_reg;
    reg [2:0]  dst_reg;
    reg [1:0]  len_reg;
    reg [2:0]  cyc_reg;
    reg [2:0]  bank_reg;
    reg        ptr_reg;
    reg        unk_reg;
    reg [7:0]  opd1_reg;
    reg [7:0]  opd2_reg;
    reg        start_reg;
    reg [15:0] dw;
    reg        known;
    reg        take_exec;

    wire       byte_taken;
    wire       tmr_busy;
    wire       tmr_last;

    // Pack class, source, destination, length and cycles
    function [15:0] pack;
        input [4:0] cls;
        input [2:0] src;
        input [2:0] dst;
        input [1:0] len;
        input [2:0] cyc;
        begin
            pack = {cls, src, dst, len, cyc};
        end
    endfunction

    // Opcode table lookup on the fetched byte
    always @* begin
        known = 1'b1;
        dw = pack(`EBCOD_CLS_NOP, `EBCOD_SRC_NONE, `EBCOD_DST_NONE, `EBCOD_LEN1, `EBCOD_CYC1);
        casez (code_data_in)
            `EBCOD_OP_NOP: begin
                known = 1'b1;
            end
            `EBCOD_OP_ADD_BANK: dw = pack(`EBCOD_CLS_ADD, `EBCOD_SRC_BANK,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_ADD_DIR: dw = pack(`EBCOD_CLS_ADD, `EBCOD_SRC_DIR,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_ADD_IND: dw = pack(`EBCOD_CLS_ADD, `EBCOD_SRC_IND,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_ADD_IMM: dw = pack(`EBCOD_CLS_ADD, `EBCOD_SRC_IMM,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_ADWC_BANK: dw = pack(`EBCOD_CLS_ADD_CARRY, `EBCOD_SRC_BANK,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_ADWC_DIR: dw = pack(`EBCOD_CLS_ADD_CARRY, `EBCOD_SRC_DIR,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_ADWC_IND: dw = pack(`EBCOD_CLS_ADD_CARRY, `EBCOD_SRC_IND,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_ADWC_IMM: dw = pack(`EBCOD_CLS_ADD_CARRY, `EBCOD_SRC_IMM,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_SBWB_BANK: dw = pack(`EBCOD_CLS_SUB_BORROW, `EBCOD_SRC_BANK,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_SBWB_DIR: dw = pack(`EBCOD_CLS_SUB_BORROW, `EBCOD_SRC_DIR,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_SBWB_IND: dw = pack(`EBCOD_CLS_SUB_BORROW, `EBCOD_SRC_IND,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_SBWB_IMM: dw = pack(`EBCOD_CLS_SUB_BORROW, `EBCOD_SRC_IMM,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_INC_ACC: dw = pack(`EBCOD_CLS_INC, `EBCOD_SRC_ACC,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_INC_BANK: dw = pack(`EBCOD_CLS_INC, `EBCOD_SRC_BANK,
                `EBCOD_DST_BANK, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_INC_DIR: dw = pack(`EBCOD_CLS_INC, `EBCOD_SRC_DIR,
                `EBCOD_DST_DIR, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_INC_IND: dw = pack(`EBCOD_CLS_INC, `EBCOD_SRC_IND,
                `EBCOD_DST_IND, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_DEC_ACC: dw = pack(`EBCOD_CLS_DEC, `EBCOD_SRC_ACC,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_DEC_BANK: dw = pack(`EBCOD_CLS_DEC, `EBCOD_SRC_BANK,
                `EBCOD_DST_BANK, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_DEC_DIR: dw = pack(`EBCOD_CLS_DEC, `EBCOD_SRC_DIR,
                `EBCOD_DST_DIR, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_DEC_IND: dw = pack(`EBCOD_CLS_DEC, `EBCOD_SRC_IND,
                `EBCOD_DST_IND, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_INC_DP16: dw = pack(`EBCOD_CLS_INC_DP16, `EBCOD_SRC_NONE,
                `EBCOD_DST_DP16, `EBCOD_LEN1, `EBCOD_CYC2);
            `EBCOD_OP_MULT: dw = pack(`EBCOD_CLS_MULT, `EBCOD_SRC_ACC,
                `EBCOD_DST_ACC_B, `EBCOD_LEN1, `EBCOD_CYC4);
            `EBCOD_OP_DIVIDE: dw = pack(`EBCOD_CLS_DIVIDE, `EBCOD_SRC_ACC,
                `EBCOD_DST_ACC_B, `EBCOD_LEN1, `EBCOD_CYC4);
            `EBCOD_OP_DEC_ADJ: dw = pack(`EBCOD_CLS_DEC_ADJ, `EBCOD_SRC_ACC,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_AND_BANK: dw = pack(`EBCOD_CLS_AND, `EBCOD_SRC_BANK,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_AND_DIR: dw = pack(`EBCOD_CLS_AND, `EBCOD_SRC_DIR,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_AND_IND: dw = pack(`EBCOD_CLS_AND, `EBCOD_SRC_IND,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_AND_IMM: dw = pack(`EBCOD_CLS_AND, `EBCOD_SRC_IMM,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_AND_TO_DIR: dw = pack(`EBCOD_CLS_AND, `EBCOD_SRC_ACC,
                `EBCOD_DST_DIR, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_AND_IMM_DIR: dw = pack(`EBCOD_CLS_AND, `EBCOD_SRC_IMM,
                `EBCOD_DST_DIR, `EBCOD_LEN3, `EBCOD_CYC2);
            `EBCOD_OP_OR_BANK: dw = pack(`EBCOD_CLS_OR, `EBCOD_SRC_BANK,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_OR_DIR: dw = pack(`EBCOD_CLS_OR, `EBCOD_SRC_DIR,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_OR_IND: dw = pack(`EBCOD_CLS_OR, `EBCOD_SRC_IND,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_OR_IMM: dw = pack(`EBCOD_CLS_OR, `EBCOD_SRC_IMM,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_OR_TO_DIR: dw = pack(`EBCOD_CLS_OR, `EBCOD_SRC_ACC,
                `EBCOD_DST_DIR, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_OR_IMM_DIR: dw = pack(`EBCOD_CLS_OR, `EBCOD_SRC_IMM,
                `EBCOD_DST_DIR, `EBCOD_LEN3, `EBCOD_CYC2);
            `EBCOD_OP_XOR_DIR: dw = pack(`EBCOD_CLS_XOR, `EBCOD_SRC_DIR,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_XOR_IND: dw = pack(`EBCOD_CLS_XOR, `EBCOD_SRC_IND,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_XOR_IMM: dw = pack(`EBCOD_CLS_XOR, `EBCOD_SRC_IMM,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_XOR_TO_DIR: dw = pack(`EBCOD_CLS_XOR, `EBCOD_SRC_ACC,
                `EBCOD_DST_DIR, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_XOR_IMM_DIR: dw = pack(`EBCOD_CLS_XOR, `EBCOD_SRC_IMM,
                `EBCOD_DST_DIR, `EBCOD_LEN3, `EBCOD_CYC2);
            `EBCOD_OP_CLEAR: dw = pack(`EBCOD_CLS_CLEAR, `EBCOD_SRC_NONE,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_COMPL: dw = pack(`EBCOD_CLS_COMPL, `EBCOD_SRC_ACC,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_SWAP: dw = pack(`EBCOD_CLS_SWAP, `EBCOD_SRC_ACC,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_ROTL: dw = pack(`EBCOD_CLS_ROTL, `EBCOD_SRC_ACC,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_ROTL_CARRY: dw = pack(`EBCOD_CLS_ROTL_CARRY, `EBCOD_SRC_ACC,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_ROTR: dw = pack(`EBCOD_CLS_ROTR, `EBCOD_SRC_ACC,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_ROTR_CARRY: dw = pack(`EBCOD_CLS_ROTR_CARRY, `EBCOD_SRC_ACC,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC1);
            `EBCOD_OP_MOV_A_DIR: dw = pack(`EBCOD_CLS_MOVE, `EBCOD_SRC_DIR,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_MOV_A_IMM: dw = pack(`EBCOD_CLS_MOVE, `EBCOD_SRC_IMM,
                `EBCOD_DST_ACC, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_MOV_BK_DIR: dw = pack(`EBCOD_CLS_MOVE, `EBCOD_SRC_DIR,
                `EBCOD_DST_BANK, `EBCOD_LEN2, `EBCOD_CYC2);
            `EBCOD_OP_MOV_BK_IMM: dw = pack(`EBCOD_CLS_MOVE, `EBCOD_SRC_IMM,
                `EBCOD_DST_BANK, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_MOV_DIR_DIR: dw = pack(`EBCOD_CLS_MOVE, `EBCOD_SRC_DIR,
                `EBCOD_DST_DIR, `EBCOD_LEN3, `EBCOD_CYC2);
            `EBCOD_OP_MOV_DIR_IMM: dw = pack(`EBCOD_CLS_MOVE, `EBCOD_SRC_IMM,
                `EBCOD_DST_DIR, `EBCOD_LEN3, `EBCOD_CYC2);
            `EBCOD_OP_MOV_DIR_A: dw = pack(`EBCOD_CLS_MOVE, `EBCOD_SRC_ACC,
                `EBCOD_DST_DIR, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_MOV_DIR_IND: dw = pack(`EBCOD_CLS_MOVE, `EBCOD_SRC_IND,
                `EBCOD_DST_DIR, `EBCOD_LEN2, `EBCOD_CYC2);
            `EBCOD_OP_MOV_IND_IMM: dw = pack(`EBCOD_CLS_MOVE, `EBCOD_SRC_IMM,
                `EBCOD_DST_IND, `EBCOD_LEN2, `EBCOD_CYC1);
            `EBCOD_OP_LOAD_DP16: dw = pack(`EBCOD_CLS_LOAD_DP16, `EBCOD_SRC_IMM16,
                `EBCOD_DST_DP16, `EBCOD_LEN3, `EBCOD_CYC2);
            `EBCOD_OP_CODE_RD: dw = pack(`EBCOD_CLS_CODE_RD, `EBCOD_SRC_CODE,
                `EBCOD_DST_ACC, `EBCOD_LEN1, `EBCOD_CYC2);
            default: begin
                known = 1'b0;
            end
        endcase
    end

    // A byte is taken whenever a fetch is asked for and acknowledged
    assign byte_taken = code_rd_out && code_ack_in;

    // Sequencer: opcode, operand bytes, then execution cycles
    always @* begin
        state_next = state_reg;
        take_exec = 1'b0;
        case (state_reg)
            `EBCOD_ST_OPC: begin
                if (byte_taken) begin
                    if (dw[4:3] == `EBCOD_LEN1) begin
                        state_next = `EBCOD_ST_EXEC;
                        take_exec = 1'b1;
                    end else begin
                        state_next = `EBCOD_ST_OPD1;
                    end
                end
            end
            `EBCOD_ST_OPD1: begin
                if (byte_taken) begin
                    if (len_reg == `EBCOD_LEN3) begin
                        state_next = `EBCOD_ST_OPD2;
                    end else begin
                        state_next = `EBCOD_ST_EXEC;
                        take_exec = 1'b1;
                    end
                end
            end
            `EBCOD_ST_OPD2: begin
                if (byte_taken) begin
                    state_next = `EBCOD_ST_EXEC;
                    take_exec = 1'b1;
                end
            end
            `EBCOD_ST_EXEC: begin
                if (tmr_last) begin
                    state_next = `EBCOD_ST_OPC;
                end
            end
            default: begin
                state_next = `EBCOD_ST_OPC;
            end
        endcase
    end

    // State, program counter and start strobe
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= `EBCOD_ST_OPC;
            pc_reg    <= RESET_PC;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            start_reg <= take_exec;
            if (byte_taken) begin
                pc_reg <= pc_reg + 16'h0001;
            end
        end
    end

    // Latch decoded fields on the opcode byte
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            opc_reg  <= 8'h00;
            cls_reg  <= `EBCOD_CLS_NOP;
            src_reg  <= `EBCOD_SRC_NONE;
            dst_reg  <= `EBCOD_DST_NONE;
            len_reg  <= `EBCOD_LEN1;
            cyc_reg  <= `EBCOD_CYC1;
            bank_reg <= 3'h0;
            ptr_reg  <= 1'b0;
            unk_reg  <= 1'b0;
        end else if (byte_taken && state_reg == `EBCOD_ST_OPC) begin
            opc_reg  <= code_data_in;
            cls_reg  <= dw[15:11];
            src_reg  <= dw[10:8];
            dst_reg  <= dw[7:5];
            len_reg  <= dw[4:3];
            cyc_reg  <= dw[2:0];
            bank_reg <= code_data_in[2:0];
            ptr_reg  <= code_data_in[0];
            unk_reg  <= ~known;
        end
    end

    // Operand bytes in fetch order
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            opd1_reg <= 8'h00;
            opd2_reg <= 8'h00;
        end else if (byte_taken) begin
            if (state_reg == `EBCOD_ST_OPC) begin
                opd1_reg <= 8'h00;
                opd2_reg <= 8'h00;
            end else if (state_reg == `EBCOD_ST_OPD1) begin
                opd1_reg <= code_data_in;
            end else begin
                opd2_reg <= code_data_in;
            end
        end
    end

    // Holds the execution phase for the decoded cycle count
    ebcod_cycle_timer #(
        .CW (3)
    ) u_timer (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .load_in    (take_exec),
        .count_in   (state_reg == `EBCOD_ST_OPC ? dw[2:0] : cyc_reg),
        .busy_out   (tmr_busy),
        .last_out   (tmr_last)
    );

    // Outputs
    assign code_rd_out     = (state_reg != `EBCOD_ST_EXEC);
    assign code_addr_out   = pc_reg;
    assign instr_start_out = start_reg;
    assign exec_active_out = tmr_busy;
    assign opcode_out      = opc_reg;
    assign op_class_out    = cls_reg;
    assign src_sel_out     = src_reg;
    assign dst_sel_out     = dst_reg;
    assign bank_idx_out    = bank_reg;
    assign ptr_idx_out     = ptr_reg;
    assign instr_len_out   = len_reg;
    assign exec_cycles_out = cyc_reg;
    assign operand1_out    = opd1_reg;
    assign operand2_out    = opd2_reg;
    assign unknown_op_out  = unk_reg;

endmodule

`default_nettype wire

// >>> core/ebcod_consts.vh
`ifndef EBCOD_CONSTS_VH
`define EBCOD_CONSTS_VH

// Sequencer states
`define EBCOD_ST_OPC        2'h0
`define EBCOD_ST_OPD1       2'h1
`define EBCOD_ST_OPD2       2'h2
`define EBCOD_ST_EXEC       2'h3

// Reset value of the program counter
`define EBCOD_RESET_PC      16'h0000

// Instruction lengths and execution cycle counts
`define EBCOD_LEN1          2'h1
`define EBCOD_LEN2          2'h2
`define EBCOD_LEN3          2'h3
`define EBCOD_CYC1          3'h1
`define EBCOD_CYC2          3'h2
`define EBCOD_CYC4          3'h4

// Operation classes
`define EBCOD_CLS_NOP       5'h00
`define EBCOD_CLS_ADD       5'h01
`define EBCOD_CLS_ADD_CARRY 5'h02
`define EBCOD_CLS_SUB_BORROW 5'h03
`define EBCOD_CLS_INC       5'h04
`define EBCOD_CLS_DEC       5'h05
`define EBCOD_CLS_INC_DP16  5'h06
`define EBCOD_CLS_MULT      5'h07
`define EBCOD_CLS_DIVIDE    5'h08
`define EBCOD_CLS_DEC_ADJ   5'h09
`define EBCOD_CLS_AND       5'h0A
`define EBCOD_CLS_OR        5'h0B
`define EBCOD_CLS_XOR       5'h0C
`define EBCOD_CLS_CLEAR     5'h0D
`define EBCOD_CLS_COMPL     5'h0E
`define EBCOD_CLS_SWAP      5'h0F
`define EBCOD_CLS_ROTL      5'h10
`define EBCOD_CLS_ROTL_CARRY 5'h11
`define EBCOD_CLS_ROTR      5'h12
`define EBCOD_CLS_ROTR_CARRY 5'h13
`define EBCOD_CLS_MOVE      5'h14
`define EBCOD_CLS_CODE_RD   5'h15
`define EBCOD_CLS_LOAD_DP16 5'h16

// Operand sources
`define EBCOD_SRC_NONE      3'h0
`define EBCOD_SRC_ACC       3'h1
`define EBCOD_SRC_BANK      3'h2
`define EBCOD_SRC_DIR       3'h3
`define EBCOD_SRC_IMM       3'h4
`define EBCOD_SRC_IND       3'h5
`define EBCOD_SRC_IMM16     3'h6
`define EBCOD_SRC_CODE      3'h7

// Destinations
`define EBCOD_DST_NONE      3'h0
`define EBCOD_DST_ACC       3'h1
`define EBCOD_DST_BANK      3'h2
`define EBCOD_DST_DIR       3'h3
`define EBCOD_DST_IND       3'h4
`define EBCOD_DST_DP16      3'h5
`define EBCOD_DST_ACC_B     3'h6

// Opcodes; bank forms match eight codes, indirect forms two
`define EBCOD_OP_NOP        8'h00
`define EBCOD_OP_ADD_BANK   8'b0010_1???
`define EBCOD_OP_ADD_DIR    8'h25
`define EBCOD_OP_ADD_IND    8'b0010_011?
`define EBCOD_OP_ADD_IMM    8'h24
`define EBCOD_OP_ADWC_BANK  8'b0011_1???
`define EBCOD_OP_ADWC_DIR   8'h35
`define EBCOD_OP_ADWC_IND   8'b0011_011?
`define EBCOD_OP_ADWC_IMM   8'h34
`define EBCOD_OP_SBWB_BANK  8'b1001_1???
`define EBCOD_OP_SBWB_DIR   8'h95
`define EBCOD_OP_SBWB_IND   8'b1001_011?
`define EBCOD_OP_SBWB_IMM   8'h94
`define EBCOD_OP_INC_ACC    8'h04
`define EBCOD_OP_INC_BANK   8'b0000_1???
`define EBCOD_OP_INC_DIR    8'h05
`define EBCOD_OP_INC_IND    8'b0000_011?
`define EBCOD_OP_DEC_ACC    8'h14
`define EBCOD_OP_DEC_BANK   8'b0001_1???
`define EBCOD_OP_DEC_DIR    8'h15
`define EBCOD_OP_DEC_IND    8'b0001_011?
`define EBCOD_OP_INC_DP16   8'hA3
`define EBCOD_OP_MULT       8'hA4
`define EBCOD_OP_DIVIDE     8'h84
`define EBCOD_OP_DEC_ADJ    8'hD4
`define EBCOD_OP_AND_BANK   8'b0101_1???
`define EBCOD_OP_AND_DIR    8'h55
`define EBCOD_OP_AND_IND    8'b0101_011?
`define EBCOD_OP_AND_IMM    8'h54
`define EBCOD_OP_AND_TO_DIR 8'h52
`define EBCOD_OP_AND_IMM_DIR 8'h53
`define EBCOD_OP_OR_BANK    8'b0100_1???
`define EBCOD_OP_OR_DIR     8'h45
`define EBCOD_OP_OR_IND     8'b0100_011?
`define EBCOD_OP_OR_IMM     8'h44
`define EBCOD_OP_OR_TO_DIR  8'h42
`define EBCOD_OP_OR_IMM_DIR 8'h43
`define EBCOD_OP_XOR_DIR    8'h65
`define EBCOD_OP_XOR_IND    8'b0110_011?
`define EBCOD_OP_XOR_IMM    8'h64
`define EBCOD_OP_XOR_TO_DIR 8'h62
`define EBCOD_OP_XOR_IMM_DIR 8'h63
`define EBCOD_OP_CLEAR      8'hE4
`define EBCOD_OP_COMPL      8'hF4
`define EBCOD_OP_SWAP       8'hC4
`define EBCOD_OP_ROTL       8'h23
`define EBCOD_OP_ROTL_CARRY 8'h33
`define EBCOD_OP_ROTR       8'h03
`define EBCOD_OP_ROTR_CARRY 8'h13
`define EBCOD_OP_MOV_A_DIR  8'hE5
`define EBCOD_OP_MOV_A_IMM  8'h74
`define EBCOD_OP_MOV_BK_DIR 8'b1010_1???
`define EBCOD_OP_MOV_BK_IMM 8'b0111_1???
`define EBCOD_OP_MOV_DIR_A  8'hF5
`define EBCOD_OP_MOV_DIR_DIR 8'h85
`define EBCOD_OP_MOV_DIR_IND 8'b1000_011?
`define EBCOD_OP_MOV_DIR_IMM 8'h75
`define EBCOD_OP_MOV_IND_IMM 8'b0111_011?
`define EBCOD_OP_LOAD_DP16  8'h90
`define EBCOD_OP_CODE_RD    8'h93

`endif

// >>> core/ebcod_cycle_timer.v
`timescale 1ns/1ps
`default_nettype none

module ebcod_cycle_timer #(
    parameter CW = 3
) (
    // Clock and reset
    input  wire          sys_clk_in,
    input  wire          resetn_in,
    // Load request
    input  wire          load_in,
    input  wire [CW-1:0] count_in,
    // Status
    output wire          busy_out,
    output wire          last_out
);

    reg [CW-1:0] cnt_reg;
    reg [CW-1:0] cnt_next;

    // Load or count down to zero
    always @* begin
        cnt_next = cnt_reg;
        if (load_in) begin
            cnt_next = count_in;
        end else if (cnt_reg != {CW{1'b0}}) begin
            cnt_next = cnt_reg - {{(CW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_reg <= {CW{1'b0}};
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // High for exactly the loaded number of cycles
    assign busy_out = (cnt_reg != {CW{1'b0}});
    assign last_out = (cnt_reg == {{(CW-1){1'b0}}, 1'b1});

endmodule

`default_nettype wire

// >>> tb/ebcod_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ebcod_properties (
    input wire logic        sys_clk_in,
    input wire logic        resetn_in,
    input wire logic        code_rd_out,
    input wire logic        code_ack_in,
    input wire logic [15:0] code_addr_out,
    input wire logic        instr_start_out,
    input wire logic        exec_active_out,
    input wire logic [7:0]  opcode_out,
    input wire logic [2:0]  bank_idx_out,
    input wire logic        ptr_idx_out,
    input wire logic [2:0]  exec_cycles_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    // Fetch pacing and execution lengths
    chk_no_fetch_exec: assert property (exec_active_out |-> !code_rd_out)
        else $error("fetch during execution");
    chk_one_cycle: assert property (instr_start_out && exec_cycles_out == 3'h1 |->
        exec_active_out ##1 !exec_active_out) else $error("one cycle execution wrong");
    chk_two_cycle: assert property (instr_start_out && exec_cycles_out == 3'h2 |->
        exec_active_out[*2] ##1 !exec_active_out) else $error("two cycle execution wrong");
    chk_mul_div_len: assert property (instr_start_out && (opcode_out == 8'hA4 ||
        opcode_out == 8'h84) |->
        exec_cycles_out == 3'h4 ##0 exec_active_out[*4] ##1 !exec_active_out)
        else $error("multiply or divide length wrong");
    chk_pc_step: assert property (code_rd_out && code_ack_in |=>
        code_addr_out == $past(code_addr_out) + 16'h0001) else $error("pc not stepped");
    chk_stall_hold: assert property (code_rd_out && !code_ack_in |=> $stable(code_addr_out))
        else $error("pc moved without a byte");
    chk_reg_select: assert property (instr_start_out |-> bank_idx_out == opcode_out[2:0]
        && ptr_idx_out == opcode_out[0]) else $error("register select wrong");
    chk_code_rd_len: assert property (instr_start_out && opcode_out == 8'h93 |->
        exec_cycles_out == 3'h2) else $error("code read length wrong");
endmodule
bind ebcod_decoder ebcod_properties u_ebcod_properties (.sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in), .code_rd_out(code_rd_out), .code_ack_in(code_ack_in),
    .code_addr_out(code_addr_out), .instr_start_out(instr_start_out),
    .exec_active_out(exec_active_out), .opcode_out(opcode_out),
    .bank_idx_out(bank_idx_out), .ptr_idx_out(ptr_idx_out),
    .exec_cycles_out(exec_cycles_out));
`default_nettype wire

// >>> tb/ebcod_code_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ebcod_code_mem (
    // Clock and pacing
    input  wire logic        sys_clk_in,
    input  wire logic        slow_in,
    // Fetch port
    input  wire logic        rd_in,
    input  wire logic [15:0] addr_in,
    output var  logic        ack_out,
    output var  logic [7:0]  data_out
);
    logic [7:0] mem [0:255];
    logic [7:0] last = 8'h00;
    logic       tog  = 1'b0;
    // Answer at once, or every other cycle; idle data is never stale
    always_comb begin
        ack_out  = rd_in & (tog | ~slow_in);
        data_out = ack_out ? mem[addr_in[7:0]] : ~last;
    end
    // Stall phase and last byte handed over
    always @(posedge sys_clk_in) begin
        tog <= ~tog;
        if (ack_out) begin
            last <= data_out;
        end
    end
endmodule
`default_nettype wire

// >>> tb/eight_bit_core_opcode_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module eight_bit_core_opcode_decoder_bench;
    logic        sys_clk_in = 1'b0;
    logic        resetn_in  = 1'b0;
    logic        slow       = 1'b0;
    logic        rd, ack, start, act, unk, ptr;
    logic [15:0] addr;
    logic [7:0]  data, opc, opd1, opd2;
    logic [4:0]  cls;
    logic [2:0]  bank, cyc, src, dst;
    logic [1:0]  len;
    int          mismatches  = 0;
    int          checks_done = 0;
    // Opcode, length, cycles and class of each probe
    localparam logic [23:0] TBL [0:49] = '{24'h281101, 24'h252101, 24'h242101, 24'h261101,
        24'h381102, 24'h342102, 24'h9F1103, 24'h942103, 24'h041104, 24'h081104, 24'h052104,
        24'h071104, 24'h141105, 24'h1F1105, 24'h152105, 24'hA31206, 24'hA41407, 24'h841408,
        24'hD41109, 24'h5F110A, 24'h54210A, 24'h52210A, 24'h53320A, 24'h48110B, 24'h42210B,
        24'h43320B, 24'h65210C, 24'h64210C, 24'h66110C, 24'h62210C, 24'h63320C, 24'hE4110D,
        24'hF4110E, 24'hC4110F, 24'h231110, 24'h331111, 24'h031112, 24'h131113, 24'hE52114,
        24'h742114, 24'hA82214, 24'h7F2114, 24'h853214, 24'h753214, 24'hF52114, 24'h872214,
        24'h762114, 24'h903216, 24'h931215, 24'hA51100};
    // Clock
    initial begin
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    ebcod_decoder u_ebcod_decoder (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .code_rd_out(rd), .code_addr_out(addr), .code_ack_in(ack), .code_data_in(data),
        .instr_start_out(start), .exec_active_out(act), .opcode_out(opc),
        .op_class_out(cls), .src_sel_out(src), .dst_sel_out(dst), .bank_idx_out(bank),
        .ptr_idx_out(ptr), .instr_len_out(len), .exec_cycles_out(cyc),
        .operand1_out(opd1), .operand2_out(opd2), .unknown_op_out(unk));
    ebcod_code_mem u_ebcod_code_mem (.sys_clk_in(sys_clk_in), .slow_in(slow), .rd_in(rd),
        .addr_in(addr), .ack_out(ack), .data_out(data));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Reset, then walk the program and judge each decoded instruction
    task run_program(input logic stall);
        logic [15:0] pc;
        logic [3:0]  l;
        int          n;
        slow = stall;
        resetn_in = 1'b0;
        repeat (10) @(posedge sys_clk_in);
        #1 resetn_in = 1'b1;
        pc = 16'h0000;
        foreach (TBL[i]) begin
            l = TBL[i][15:12];
            for (n = 0; n < 40 && start !== 1'b1; n++) begin
                @(posedge sys_clk_in);
                #1;
            end
            chk(start, 1'b1);
            chk(opc, TBL[i][23:16]);
            chk(len, l);
            chk(cyc, TBL[i][11:8]);
            chk(cls, TBL[i][7:0]);
            chk(unk, TBL[i][23:16] == 8'hA5);
            chk(addr, pc + l);
            chk(opd1, l > 1 ? pc + 16'h0001 : 16'h0000);
            chk(opd2, l > 2 ? pc + 16'h0002 : 16'h0000);
            chk({bank, ptr}, {TBL[i][18:16], TBL[i][16]});
            if (TBL[i][23:16] == 8'hA4) chk({src, dst}, 6'h0E);
            if (TBL[i][23:16] == 8'h90) chk({src, dst}, 6'h35);
            for (n = 0; n < 8 && act === 1'b1; n++) begin
                @(posedge sys_clk_in);
                #1;
            end
            chk(n, TBL[i][11:8]);
            pc = pc + l;
        end
    endtask
    task scen_prompt_memory;
        run_program(1'b0);
    endtask
    task scen_stalling_memory;
        run_program(1'b1);
    endtask
    // Program image: operands carry their own address
    initial begin
        logic [15:0] a;
        a = 16'h0000;
        for (int k = 0; k < 256; k++) begin
            u_ebcod_code_mem.mem[k] = 8'(k);
        end
        foreach (TBL[i]) begin
            u_ebcod_code_mem.mem[a[7:0]] = TBL[i][23:16];
            a = a + TBL[i][15:12];
        end
        scen_prompt_memory();
        scen_stalling_memory();
        summarize();
    end
    // Cut a hang short
    initial begin
        #200000;
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
